//--- rtl/dpc_consts.vh
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH

// Serial word layout.
`define DPC_WORD_BITS      24
`define DPC_CMD_HI         23
`define DPC_CMD_LO         20
`define DPC_ADR_HI         19
`define DPC_ADR_LO         16
`define DPC_DAT_HI         15
`define DPC_WIPER_HI       9
`define DPC_BIT_LAST       6'h17

// Command codes.
`define DPC_CMD_NOP        4'h0
`define DPC_CMD_RESTORE    4'h1
`define DPC_CMD_STORE_W    4'h2
`define DPC_CMD_STORE_NV   4'h3
`define DPC_CMD_DEC6       4'h4
`define DPC_CMD_DEC6_ALL   4'h5
`define DPC_CMD_DEC1       4'h6
`define DPC_CMD_DEC1_ALL   4'h7
`define DPC_CMD_RESTORE_AL 4'h8
`define DPC_CMD_READ_NV    4'h9
`define DPC_CMD_READ_W     4'hA
`define DPC_CMD_WRITE_W    4'hB
`define DPC_CMD_INC6       4'hC
`define DPC_CMD_INC6_ALL   4'hD
`define DPC_CMD_INC1       4'hE
`define DPC_CMD_INC1_ALL   4'hF

// Addresses and values.
`define DPC_ADR_CH1        4'h0
`define DPC_ADR_CH2        4'h1
`define DPC_ADR_USER_LO    4'h2
`define DPC_ADR_USER_HI    4'hE
`define DPC_ADR_RESERVED   4'hF
`define DPC_NV_DEPTH       5'h10
`define DPC_WIPER_MID      10'h200
`define DPC_WIPER_MAX      10'h3FF
`define DPC_WIPER_MIN      10'h000
`define DPC_NV_DEFAULT     16'h0200

// Busy times in microseconds, and the clock rate in MHz.
`define DPC_STORE_US       15000
`define DPC_READ_US        7
`define DPC_RELOAD_US      20
`define DPC_PRESET_US      30
`define DPC_CLK_MHZ        250

`endif

//--- rtl/dpc_core.v
`timescale 1ns/1ps
`default_nettype none
`include "dpc_consts.vh"

module dpc_core #(
    parameter CLK_MHZ     = `DPC_CLK_MHZ,
    parameter STORE_TICKS = `DPC_STORE_US * CLK_MHZ,
    parameter READ_TICKS  = `DPC_READ_US * CLK_MHZ,
    parameter LOAD_TICKS  = `DPC_RELOAD_US * CLK_MHZ,
    parameter PRES_TICKS  = `DPC_PRESET_US * CLK_MHZ
) (
    input  wire       clock_i,
    input  wire       rst_b_i,
    input  wire       sclk_i,
    input  wire       sdi_i,
    input  wire       cs_b_i,
    input  wire       wp_b_i,
    input  wire       nv_reload_strobe_n_i,
    output reg        sdo_o,
    output reg        sdo_oe_o,
    output reg        rdy_o,
    output reg        rdy_oe_o,
    output reg  [9:0] wiper_setting_ch1_o,
    output reg  [9:0] wiper_setting_ch2_o
);

    // Controller states. Boot walks the storage once and then loads both wipers,
    // so no frame can be taken before the first ready.
    localparam ST_IDLE = 2'h0;
    localparam ST_BUSY = 2'h1;
    localparam ST_BOOT = 2'h2;

    wire [3:0]  pins_s;
    reg  [3:0]  pins_d;
    reg  [23:0] shreg;
    reg  [23:0] outreg;
    reg  [5:0]  bitcnt;
    reg         any_bits;
    reg  [23:0] last_word;
    reg         have_last;
    reg  [15:0] nvmem [0:15];
    reg  [1:0]  state;
    reg  [23:0] busy_cnt;
    reg  [4:0]  boot_idx;

    // Synchronised pin levels and their edges. Every edge is seen about three clocks after
    // the pin moves, so the host must leave a few clocks between a data change and its link edge.
    wire sclk_s = pins_s[0];
    wire sdi_s  = pins_s[1];
    wire cs_s   = pins_s[2];
    wire pr_s   = pins_s[3];
    wire sclk_rise = sclk_s & ~pins_d[0];
    wire sclk_fall = ~sclk_s & pins_d[0];
    wire cs_rise   = cs_s & ~pins_d[2];
    wire cs_fall   = ~cs_s & pins_d[2];
    wire pr_fall   = ~pr_s & pins_d[3];
    wire pr_rise   = pr_s & ~pins_d[3];
    wire wp_s;
    reg  wp_q1;
    reg  wp_q2;

    dpc_sync #(.WIDTH(4), .INIT(4'hE)) u_sync (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .async_i ({nv_reload_strobe_n_i, cs_b_i, sdi_i, sclk_i}),
        .sync_o  (pins_s)
    );

    // Write protect is a slow level; its own two flops keep it apart.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wp_q1 <= 1'b1;
            wp_q2 <= 1'b1;
        end else begin
            wp_q1 <= wp_b_i;
            wp_q2 <= wp_q1;
        end
    end
    assign wp_s = wp_q2;

    // Saturating single step.
    function [9:0] step;
        input [9:0] v;
        input       up;
        begin
            if (up)
                step = (v == `DPC_WIPER_MAX) ? v : v + 10'h001;
            else
                step = (v == `DPC_WIPER_MIN) ? v : v - 10'h001;
        end
    endfunction

    // Saturating 6 dB move: doubling clamps at full scale, halving floors.
    // Doubling from the upper half would overflow, so it pins at the top code instead.
    function [9:0] six_db;
        input [9:0] v;
        input       up;
        begin
            if (up)
                six_db = v[9] ? `DPC_WIPER_MAX : {v[8:0], 1'b0};
            else
                six_db = {1'b0, v[9:1]};
        end
    endfunction

    // Stored value as a wiper code, only the low ten bits count.
    function [9:0] nv_wiper;
        input [15:0] w;
        begin
            nv_wiper = w[`DPC_WIPER_HI:0];
        end
    endfunction

    // Frame accepted when a whole multiple of four bits arrived. Odd counts usually mean a
    // glitch on the link clock, and executing such a word could move a wiper at random.
    wire        frame_ok = any_bits && (bitcnt[1:0] == 2'b00);
    // No clocks at all repeats the previous word.
    wire        repeat_ok = !any_bits && have_last;
    // The executed word is the one just shifted in, or the last word for a bare pulse.
    wire [23:0] exec_word = any_bits ? shreg : last_word;
    wire [3:0]  e_cmd = exec_word[`DPC_CMD_HI:`DPC_CMD_LO];
    wire [3:0]  e_adr = exec_word[`DPC_ADR_HI:`DPC_ADR_LO];
    wire [15:0] e_dat = exec_word[`DPC_DAT_HI:0];
    wire        e_ch2 = e_adr[0];
    // A repeat needs a previous word; none exists straight after reset.
    wire        do_exec = cs_rise && state == ST_IDLE && (frame_ok || repeat_ok);

    // Pin edge history.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)
            pins_d <= 4'hE;
        else
            pins_d <= pins_s;
    end

    // Input shift register, locked while a store or load is pending.
    // The counter wraps at a whole word, so a chained 48-bit frame still ends on a multiple of four.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shreg    <= 24'h000000;
            bitcnt   <= 6'h00;
            any_bits <= 1'b0;
        end else if (cs_fall) begin
            any_bits <= 1'b0;
            bitcnt   <= 6'h00;
        end else if (!cs_s && sclk_rise && state == ST_IDLE) begin
            shreg    <= {shreg[22:0], sdi_s};
            any_bits <= 1'b1;
            bitcnt   <= (bitcnt == `DPC_BIT_LAST) ? 6'h00 : bitcnt + 6'h01;
        end else if (cs_rise && !frame_ok) begin
            bitcnt <= 6'h00;
        end
    end

    // Output word: echo the previous word, or read-back data after 9 and 10.
    // The pin is open drain: it is pulled low only for zero bits and let go while deselected,
    // so the pull-up carries the ones and a chained device sees an idle high line.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            outreg   <= 24'h000000;
            sdo_o    <= 1'b1;
            sdo_oe_o <= 1'b0;
        end else begin
            sdo_oe_o <= 1'b0;
            sdo_o    <= 1'b1;
            if (!cs_s) begin
                sdo_oe_o <= ~outreg[`DPC_CMD_HI];
                sdo_o    <= 1'b0;
            end
            if (do_exec && e_cmd == `DPC_CMD_READ_NV)
                outreg <= {e_cmd, e_adr, nvmem[e_adr]};
            else if (do_exec && e_cmd == `DPC_CMD_READ_W)
                outreg <= {e_cmd, e_adr, 6'h00,
                           e_ch2 ? wiper_setting_ch2_o : wiper_setting_ch1_o};
            else if (cs_fall && !(have_last && (last_word[`DPC_CMD_HI:`DPC_CMD_LO] == `DPC_CMD_READ_NV ||
                                                last_word[`DPC_CMD_HI:`DPC_CMD_LO] == `DPC_CMD_READ_W)))
                outreg <= shreg;
            // Shifting on the falling edge keeps each bit steady across the host's next rising edge.
            else if (!cs_s && sclk_fall && any_bits)
                outreg <= {outreg[22:0], shreg[23]};
        end
    end

    // Command execution, stores, reloads and ready timing.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state               <= ST_BOOT;
            busy_cnt            <= 24'h000000;
            boot_idx            <= 5'h00;
            have_last           <= 1'b0;
            last_word           <= 24'h000000;
            wiper_setting_ch1_o <= `DPC_WIPER_MID;
            wiper_setting_ch2_o <= `DPC_WIPER_MID;
            rdy_o               <= 1'b0;
            rdy_oe_o            <= 1'b1;
        end else begin
            case (state)
                ST_BOOT: begin
                    // Storage holds factory midscale until written.
                    if (boot_idx < `DPC_NV_DEPTH) begin
                        nvmem[boot_idx[3:0]] <= `DPC_NV_DEFAULT;
                        boot_idx <= boot_idx + 5'h01;
                    end else begin
                        wiper_setting_ch1_o <= nv_wiper(nvmem[`DPC_ADR_CH1]);
                        wiper_setting_ch2_o <= nv_wiper(nvmem[`DPC_ADR_CH2]);
                        state    <= ST_IDLE;
                        rdy_o    <= 1'b1;
                        rdy_oe_o <= 1'b0;
                    end
                end
                ST_BUSY: begin
                    // Link edges seen meanwhile are dropped; the host waits for ready first.
                    if (busy_cnt == 24'h000000) begin
                        state    <= ST_IDLE;
                        rdy_o    <= 1'b1;
                        rdy_oe_o <= 1'b0;
                    end else begin
                        busy_cnt <= busy_cnt - 24'h000001;
                    end
                end
                ST_IDLE: begin
                    // Preset low parks both wipers at midscale; the stored value returns on release.
                    if (pr_fall) begin
                        wiper_setting_ch1_o <= `DPC_WIPER_MID;
                        wiper_setting_ch2_o <= `DPC_WIPER_MID;
                    end else if (pr_rise) begin
                        wiper_setting_ch1_o <= nv_wiper(nvmem[`DPC_ADR_CH1]);
                        wiper_setting_ch2_o <= nv_wiper(nvmem[`DPC_ADR_CH2]);
                        busy_cnt <= PRES_TICKS[23:0];
                        state    <= ST_BUSY;
                        rdy_o    <= 1'b0;
                        rdy_oe_o <= 1'b1;
                    end else if (do_exec) begin
                        last_word <= exec_word;
                        have_last <= 1'b1;
                        case (e_cmd)
                            `DPC_CMD_RESTORE: begin
                                if (e_ch2)
                                    wiper_setting_ch2_o <= nv_wiper(nvmem[`DPC_ADR_CH2]);
                                else
                                    wiper_setting_ch1_o <= nv_wiper(nvmem[`DPC_ADR_CH1]);
                            end
                            `DPC_CMD_STORE_W: begin
                                // Ready still drops under protection, so host timing is the same.
                                if (wp_s) begin
                                    if (e_ch2)
                                        nvmem[`DPC_ADR_CH2] <= {6'h00, wiper_setting_ch2_o};
                                    else
                                        nvmem[`DPC_ADR_CH1] <= {6'h00, wiper_setting_ch1_o};
                                end
                                busy_cnt <= STORE_TICKS[23:0];
                            end
                            `DPC_CMD_STORE_NV: begin
                                // Address 15 is reserved and never written by a store.
                                if (wp_s && e_adr != `DPC_ADR_RESERVED)
                                    nvmem[e_adr] <= e_dat;
                                busy_cnt <= STORE_TICKS[23:0];
                            end
                            `DPC_CMD_RESTORE_AL: begin
                                wiper_setting_ch1_o <= nv_wiper(nvmem[`DPC_ADR_CH1]);
                                wiper_setting_ch2_o <= nv_wiper(nvmem[`DPC_ADR_CH2]);
                                busy_cnt <= LOAD_TICKS[23:0];
                            end
                            `DPC_CMD_READ_NV, `DPC_CMD_READ_W: begin
                                busy_cnt <= READ_TICKS[23:0];
                            end
                            `DPC_CMD_WRITE_W: begin
                                if (wp_s) begin
                                    if (e_ch2)
                                        wiper_setting_ch2_o <= e_dat[`DPC_WIPER_HI:0];
                                    else
                                        wiper_setting_ch1_o <= e_dat[`DPC_WIPER_HI:0];
                                end
                            end
                            `DPC_CMD_DEC6, `DPC_CMD_INC6, `DPC_CMD_DEC1, `DPC_CMD_INC1: begin
                                // Bit 3 gives direction, bit 1 picks step or 6 dB.
                                if (wp_s) begin
                                    if (e_ch2)
                                        wiper_setting_ch2_o <= e_cmd[1] ? step(wiper_setting_ch2_o, e_cmd[3])
                                                                        : six_db(wiper_setting_ch2_o, e_cmd[3]);
                                    else
                                        wiper_setting_ch1_o <= e_cmd[1] ? step(wiper_setting_ch1_o, e_cmd[3])
                                                                        : six_db(wiper_setting_ch1_o, e_cmd[3]);
                                end
                            end
                            `DPC_CMD_DEC6_ALL, `DPC_CMD_INC6_ALL, `DPC_CMD_DEC1_ALL, `DPC_CMD_INC1_ALL: begin
                                if (wp_s) begin
                                    wiper_setting_ch1_o <= e_cmd[1] ? step(wiper_setting_ch1_o, e_cmd[3])
                                                                    : six_db(wiper_setting_ch1_o, e_cmd[3]);
                                    wiper_setting_ch2_o <= e_cmd[1] ? step(wiper_setting_ch2_o, e_cmd[3])
                                                                    : six_db(wiper_setting_ch2_o, e_cmd[3]);
                                end
                            end
                            default: begin
                                // No operation, but the word is still kept for a later repeat.
                                busy_cnt <= busy_cnt;
                            end
                        endcase
                        // Ready drops for the slow commands only.
                        // Command 1 moves one wiper and finishes at once, so it leaves ready alone.
                        if (e_cmd == `DPC_CMD_STORE_W || e_cmd == `DPC_CMD_STORE_NV ||
                            e_cmd == `DPC_CMD_RESTORE_AL || e_cmd == `DPC_CMD_READ_NV ||
                            e_cmd == `DPC_CMD_READ_W) begin
                            state    <= ST_BUSY;
                            rdy_o    <= 1'b0;
                            rdy_oe_o <= 1'b1;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- rtl/dpc_sync.v
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of pin levels.
module dpc_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    input  wire             clock_i,
    input  wire             rst_b_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] stage1;

    // The first stage is read only by the second stage.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage1 <= INIT;
            sync_o <= INIT;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule
`default_nettype wire

//--- test/dpc_core_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Pin-level checks: serial release, execution point, ready and preset behaviour.
module dpc_core_sva #(
    parameter READ_TICKS = 1750
) (
    input wire logic       clock_i,
    input wire logic       rst_b_i,
    input wire logic       sclk_i,
    input wire logic       sdi_i,
    input wire logic       cs_b_i,
    input wire logic       wp_b_i,
    input wire logic       nv_reload_strobe_n_i,
    input wire logic       sdo_o,
    input wire logic       sdo_oe_o,
    input wire logic       rdy_o,
    input wire logic       rdy_oe_o,
    input wire logic [9:0] wiper_setting_ch1_o,
    input wire logic [9:0] wiper_setting_ch2_o
);
    default clocking dc @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    // Length of the low-ready run. The first rise after reset ends the short storage init,
    // which is not a command, so it is skipped.
    int   low_run;
    logic armed;
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            low_run <= 0;
            armed <= 1'b0;
        end else begin
            low_run <= rdy_o ? 0 : low_run + 1;
            armed <= armed | rdy_o;
        end
    end

    AST_SDO_RELEASE: assert property (cs_b_i [*5] |-> !sdo_oe_o)
        else $error("serial output driven while deselected");
    AST_EXEC_AT_RISE: assert property ((!cs_b_i && nv_reload_strobe_n_i) [*5] |->
        $stable(wiper_setting_ch1_o) && $stable(wiper_setting_ch2_o))
        else $error("wiper changed while selected");
    AST_PRESET_MID: assert property ((!nv_reload_strobe_n_i) [*5] |->
        wiper_setting_ch1_o == 10'h200 && wiper_setting_ch2_o == 10'h200)
        else $error("wipers not midscale during preset");
    AST_PRESET_BUSY: assert property ($rose(nv_reload_strobe_n_i) |-> ##[1:8] !rdy_o)
        else $error("no busy after preset release");
    AST_RDY_HOLD: assert property ($fell(rdy_o) |-> (!rdy_o) [*8])
        else $error("ready low too briefly");
    AST_BUSY_MIN: assert property ($rose(rdy_o) && armed |-> low_run >= READ_TICKS)
        else $error("busy shorter than the shortest operation");
    AST_RDY_PIN: assert property (rdy_oe_o == !rdy_o)
        else $error("ready drive out of step with ready value");
    AST_RDY_AFTER_CS: assert property ($fell(rdy_o) |-> cs_b_i)
        else $error("ready fell while still selected");

    COV_BUSY: cover property ($fell(rdy_o));
    COV_PRESET: cover property ($rose(nv_reload_strobe_n_i));
    COV_FRAME: cover property ($rose(cs_b_i) ##[1:8] $fell(rdy_o));
endmodule

bind dpc_core dpc_core_sva #(.READ_TICKS(READ_TICKS)) i_sva (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .sclk_i(sclk_i), .sdi_i(sdi_i), .cs_b_i(cs_b_i),
    .wp_b_i(wp_b_i), .nv_reload_strobe_n_i(nv_reload_strobe_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .rdy_o(rdy_o), .rdy_oe_o(rdy_oe_o), .wiper_setting_ch1_o(wiper_setting_ch1_o),
    .wiper_setting_ch2_o(wiper_setting_ch2_o));

`default_nettype wire

//--- test/dpc_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host master model: the link clock idles low and only runs inside frames.
module dpc_host (
    input  wire logic clock_i,
    input  wire logic sdo_i,
    output var  logic sclk_o,
    output var  logic sdi_o,
    output var  logic cs_b_o
);
    // Idle levels from time zero.
    initial begin
        sclk_o = 1'b0;
        sdi_o = 1'b1;
        cs_b_o = 1'b1;
    end

    // Sends n bits from bit 23 down at a 48 ns link period. The reply is sampled on a falling
    // system edge just before each link rise, clear of the output's own update edge.
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
        r = 24'h0;
        @(posedge clock_i) cs_b_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi_o <= w[23-i];
            repeat (5) @(posedge clock_i);
            @(negedge clock_i) r = {r[22:0], sdo_i};
            @(posedge clock_i) sclk_o <= 1'b1;
            repeat (6) @(posedge clock_i);
            sclk_o <= 1'b0;
        end
        repeat (12) @(posedge clock_i);
        cs_b_o <= 1'b1;
        sdi_o <= ~sdi_o;
    endtask
endmodule

`default_nettype wire

//--- test/test_dpc_core.sv
`timescale 1ns/1ps
`default_nettype none

module test_dpc_core;
    logic        clock_i, rst_b_i, wp_b, nv_reload_strobe_n;
    logic        sclk, sdi, cs_b, sdo, sdo_oe, rdy, rdy_oe;
    logic [9:0]  w1, w2, e1, e2;
    logic [23:0] rd;
    logic [3:0]  ops [8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF};
    int          n_fail = 0;
    int          n_checks = 0;
    wire logic   sdo_line;

    // Open-drain output with a pull-up: released reads high.
    assign sdo_line = sdo_oe ? sdo : 1'b1;

    // Short busy spans keep the run brief; expectations do not depend on them.
    dpc_core #(.STORE_TICKS(200), .READ_TICKS(20), .LOAD_TICKS(30), .PRES_TICKS(40)) i_dut (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .sclk_i(sclk), .sdi_i(sdi), .cs_b_i(cs_b), .wp_b_i(wp_b),
        .nv_reload_strobe_n_i(nv_reload_strobe_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .rdy_o(rdy),
        .rdy_oe_o(rdy_oe), .wiper_setting_ch1_o(w1), .wiper_setting_ch2_o(w2));
    dpc_host i_host (.clock_i(clock_i), .sdo_i(sdo_line), .sclk_o(sclk), .sdi_o(sdi), .cs_b_o(cs_b));

    // Compares and counts.
    task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_wip();
        chk_word({4'h0, w1, w2}, {4'h0, e1, e2});
    endtask

    task automatic note(input string s);
        $display("%0s done: %0d checks, %0d bad", s, n_checks, n_fail);
    endtask

    // Bounded wait for ready; the store is the longest busy span here.
    task automatic wait_rdy();
        for (int i = 0; i < 1000 && rdy !== 1'b1; i++)
            @(negedge clock_i);
        chk_word({23'h0, rdy}, 24'h1);
    endtask

    // One whole frame, then the busy flag once the command has had time to start.
    task automatic send(input logic [23:0] w, input logic busy);
        i_host.xfer(w, 24, rd);
        repeat (10) @(negedge clock_i);
        chk_word({23'h0, !rdy}, {23'h0, busy});
        chk_word({23'h0, rdy_oe}, {23'h0, busy});
        wait_rdy();
        repeat (45) @(negedge clock_i);
    endtask

    // Expected wiper after a step or 6 dB move; both directions stop at the end codes.
    function automatic logic [9:0] mv(input logic [3:0] c, input logic [9:0] v);
        if (c[1])
            return c[3] ? ((v == 10'h3FF) ? v : v + 10'h1) : ((v == 10'h000) ? v : v - 10'h1);
        return c[3] ? ((v >= 10'h200) ? 10'h3FF : {v[8:0], 1'b0}) : {1'b0, v[9:1]};
    endfunction

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // Watchdog at about four times the expected run of some 50 us.
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end

    initial begin
        rst_b_i = 1'b0;
        wp_b = 1'b1;
        nv_reload_strobe_n = 1'b1;
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        wait_rdy();
        e1 = 10'h200;
        e2 = 10'h200;
        chk_wip();
        note("power-up");
        send(24'hB00100, 1'b0);
        send(24'hB1FFFF, 1'b0);
        e1 = 10'h100;
        e2 = 10'h3FF;
        chk_wip();
        send(24'h000000, 1'b0);
        chk_word(rd, 24'hB1FFFF);
        send(24'hA00000, 1'b1);
        send(24'h000000, 1'b0);
        chk_word(rd, 24'hA00100);
        note("write and read");
        send(24'h200000, 1'b1);
        send(24'hB00055, 1'b0);
        send(24'h100000, 1'b0);
        chk_wip();
        send(24'h35BEEF, 1'b1);
        send(24'h950000, 1'b1);
        send(24'h000000, 1'b0);
        chk_word(rd, 24'h95BEEF);
        note("store");
        for (int p = 0; p < 2; p++)
            foreach (ops[k]) begin
                send({ops[k], 3'h0, p[0], 16'h0}, 1'b0);
                if (ops[k][0] || !p[0]) e1 = mv(ops[k], e1);
                if (ops[k][0] || p[0]) e2 = mv(ops[k], e2);
                chk_wip();
            end
        note("steps");
        @(posedge clock_i) wp_b <= 1'b0;
        send(24'hB00001, 1'b0);
        send(24'hF00000, 1'b0);
        chk_wip();
        send(24'h800000, 1'b1);
        e1 = 10'h100;
        e2 = 10'h200;
        chk_wip();
        @(posedge clock_i) wp_b <= 1'b1;
        note("protect");
        send(24'hB003FF, 1'b0);
        @(posedge clock_i) nv_reload_strobe_n <= 1'b0;
        repeat (20) @(negedge clock_i);
        e1 = 10'h200;
        chk_wip();
        @(posedge clock_i) nv_reload_strobe_n <= 1'b1;
        repeat (10) @(negedge clock_i);
        chk_word({23'h0, rdy}, 24'h0);
        wait_rdy();
        e1 = 10'h100;
        chk_wip();
        note("preset");
        i_host.xfer(24'hB00333, 23, rd);
        repeat (60) @(negedge clock_i);
        chk_wip();
        send(24'hE00000, 1'b0);
        i_host.xfer(24'h0, 0, rd);
        repeat (60) @(negedge clock_i);
        e1 = 10'h102;
        chk_wip();
        note("framing");
        print_verdict();
    end
endmodule

`default_nettype wire
